// *** common/sads_cfg_if.sv ***
// interface: configuration and events from the register file to the sequencer, busy, done and result back
`default_nettype none
interface sads_cfg_if;
	logic enable;
	logic hw_start;
	logic [2:0] conv_code;
	logic [1:0] edge_sel;
	logic [1:0] channel;
	logic restart;
	logic busy;
	logic done;
	logic [7:0] result;
	modport regs (output enable, hw_start, conv_code, edge_sel, channel, restart,
		input busy, done, result);
	modport seq (input enable, hw_start, conv_code, edge_sel, channel, restart,
		output busy, done, result);
endinterface
`default_nettype wire

// *** common/sads_pkg.sv ***
// package: register map, field positions, timing tables for the converter sequencer
`default_nettype none
package sads_pkg;
	// byte addresses of the register words
	localparam logic [15:0] SADS_MODE_ADDR = 16'hff80;
	localparam logic [15:0] SADS_CHAN_ADDR = 16'hff81;
	// byte addresses actually decoded (index times four, since ff81 is not word aligned)
	localparam logic [17:0] SADS_MODE_BADDR = 18'h3fe00;
	localparam logic [17:0] SADS_CHAN_BADDR = 18'h3fe04;
	// own registers: result word and status word
	localparam logic [17:0] SADS_RESULT_BADDR = 18'h3fe08;
	localparam logic [17:0] SADS_STATUS_BADDR = 18'h3fe0c;
	// mode register fields
	localparam int SADS_EN_BIT = 7;
	localparam int SADS_TRG_BIT = 6;
	localparam int SADS_FR_LSB = 3;
	localparam int SADS_EDGE_LSB = 1;
	// status register fields
	localparam int SADS_ST_DONE_BIT = 0;
	localparam int SADS_ST_BUSY_BIT = 1;
	// reset values
	localparam logic [7:0] SADS_MODE_RST = 8'h00;
	localparam logic [7:0] SADS_CHAN_RST = 8'h00;
	localparam logic [7:0] SADS_RESULT_RST = 8'h00;
	// main clock, MHz, figure as printed as clock rate
	localparam int SADS_CLK_MHZ = 250;
	// start delay in main-clock periods (long and short code groups, taken at minimum)
	localparam logic [3:0] SADS_DLY_LONG = 4'h6;
	localparam logic [3:0] SADS_DLY_SHORT = 4'h3;
	// half a cpu clock, cycles, cpu clock taken equal to main clock, rounded up
	localparam logic [3:0] SADS_DLY_HALF = 4'h1;
	localparam int SADS_BITS = 8;
	typedef enum logic [1:0] {SADS_IDLE, SADS_DELAY, SADS_SAMPLE, SADS_CONVERT} sads_state_t;
	// total conversion length per code, prohibited codes take the code 0 length
	function automatic logic [7:0] sads_conv_len(input logic [2:0] code);
		case (code)
			3'h0: sads_conv_len = 8'h90;
			3'h1: sads_conv_len = 8'h78;
			3'h2: sads_conv_len = 8'h60;
			3'h4: sads_conv_len = 8'h48;
			3'h5: sads_conv_len = 8'h3c;
			3'h6: sads_conv_len = 8'h30;
			default: sads_conv_len = 8'h90;
		endcase
	endfunction
	// sampling length per code
	function automatic logic [7:0] sads_samp_len(input logic [2:0] code);
		case (code)
			3'h0: sads_samp_len = 8'h14;
			3'h1: sads_samp_len = 8'h10;
			3'h2: sads_samp_len = 8'h0c;
			3'h4: sads_samp_len = 8'h0a;
			3'h5: sads_samp_len = 8'h08;
			3'h6: sads_samp_len = 8'h06;
			default: sads_samp_len = 8'h14;
		endcase
	endfunction
endpackage
`default_nettype wire

// *** logic/sads_edge_det.sv ***
// trigger edge detector with selectable falling, rising or both edges
`default_nettype none
module sads_edge_det
	import sads_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// trigger and selection
	input wire logic trig_in,
	input wire logic [1:0] edge_sel,
	// one-cycle edge pulse
	output logic edge_hit
);
	logic prev_ff;
	logic nxt_prev;

	// previous trigger level
	always_comb begin
		nxt_prev = trig_in;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_ff <= 1'b0;
		end else begin
			prev_ff <= nxt_prev;
		end
	end

	// low select bit falling, high select bit rising
	always_comb begin
		edge_hit = (edge_sel[0] & prev_ff & ~trig_in) |
			(edge_sel[1] & ~prev_ff & trig_in);
	end
endmodule
`default_nettype wire

// *** logic/sads_seq.sv ***
// successive approximation sequencer: delay, sample, eight trials, result latch
`default_nettype none
module sads_seq
	import sads_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// configuration from register file
	sads_cfg_if.seq cfg,
	// standby and trigger
	input wire logic standby,
	input wire logic edge_hit,
	// analog side
	input wire logic comp_high,
	output logic sample_en,
	output logic [7:0] tap_code,
	output logic [1:0] mux_sel,
	// done pulse
	output logic done_req
);
	sads_state_t state_ff, nxt_state;
	logic [7:0] cnt_ff, nxt_cnt;
	logic [7:0] sar_ff, nxt_sar;
	logic [2:0] bit_ff, nxt_bit;
	logic [7:0] res_ff, nxt_res;
	logic done_ff, nxt_done;
	logic armed_ff, nxt_armed;
	logic [7:0] step;
	logic [7:0] span;
	logic [7:0] lead;

	// trial period: remaining cycles split over eight bits
	always_comb begin
		span = sads_conv_len(cfg.conv_code) - sads_samp_len(cfg.conv_code);
		step = span >> 3;
		// first trial absorbs the leftover so the total matches the code
		lead = step + {5'h00, span[2:0]};
	end

	// next-state logic
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_sar = sar_ff;
		nxt_bit = bit_ff;
		nxt_res = res_ff;
		nxt_done = 1'b0;
		nxt_armed = armed_ff;
		if (!cfg.enable || standby) begin
			nxt_state = SADS_IDLE;
			nxt_armed = 1'b0;
		end else if (cfg.restart) begin
			// new channel or enable rewrite aborts and restarts
			nxt_state = SADS_IDLE;
			nxt_armed = ~cfg.hw_start;
			nxt_cnt = 8'h00;
		end else begin
			case (state_ff)
				SADS_IDLE: begin
					if (!cfg.hw_start || edge_hit || armed_ff) begin
						nxt_state = SADS_DELAY;
						nxt_armed = 1'b0;
						// the idle cycle itself is the first delay cycle
						nxt_cnt = {4'h0, SADS_DLY_HALF} + {4'h0, (cfg.conv_code[2] ?
							SADS_DLY_SHORT : SADS_DLY_LONG)} - 8'h01;
					end
				end
				SADS_DELAY: begin
					if (cnt_ff <= 8'h01) begin
						nxt_state = SADS_SAMPLE;
						nxt_cnt = sads_samp_len(cfg.conv_code);
					end else begin
						nxt_cnt = cnt_ff - 8'h01;
					end
				end
				SADS_SAMPLE: begin
					if (cnt_ff <= 8'h01) begin
						nxt_state = SADS_CONVERT;
						nxt_sar = 8'h80;
						nxt_bit = 3'h7;
						nxt_cnt = lead;
					end else begin
						nxt_cnt = cnt_ff - 8'h01;
					end
				end
				SADS_CONVERT: begin
					if (cnt_ff <= 8'h01) begin
						// decide current bit, set next lower one
						nxt_sar = sar_ff;
						nxt_sar[bit_ff] = comp_high;
						nxt_cnt = step;
						if (bit_ff == 3'h0) begin
							nxt_res = nxt_sar;
							nxt_done = 1'b1;
							nxt_state = cfg.hw_start ? SADS_IDLE : SADS_DELAY;
							nxt_cnt = 8'h01;
						end else begin
							nxt_bit = bit_ff - 3'h1;
							nxt_sar[bit_ff - 3'h1] = 1'b1;
						end
					end else begin
						nxt_cnt = cnt_ff - 8'h01;
					end
				end
				default: nxt_state = SADS_IDLE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= SADS_IDLE;
			cnt_ff <= 8'h00;
			sar_ff <= 8'h00;
			bit_ff <= 3'h7;
			res_ff <= SADS_RESULT_RST;
			done_ff <= 1'b0;
			armed_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			sar_ff <= nxt_sar;
			bit_ff <= nxt_bit;
			res_ff <= nxt_res;
			done_ff <= nxt_done;
			armed_ff <= nxt_armed;
		end
	end

	// outputs to analog side and register file
	always_comb begin
		sample_en = (state_ff == SADS_SAMPLE);
		tap_code = sar_ff; // tap follows trial value
		mux_sel = cfg.channel;
		done_req = done_ff;
		cfg.done = done_ff;
		cfg.result = res_ff;
		cfg.busy = (state_ff != SADS_IDLE);
	end
endmodule
`default_nettype wire

// *** logic/sads_top.sv ***
// converter sequencer top: AHB-Lite register file plus sequencer and trigger detector
`default_nettype none
// Contract
// - enable bit stops or runs repeated conversion
// - trigger-source bit: software or external edge
// - conversion code sets total length
// - sampling length follows conversion code
// - start delay after enable per code group
// - edge field picks none, fall, rise, both
// - channel code routes one of four inputs
// - hold, then top trial bit, half tap
// - keep bit if input at or above tap
// - eight trials then copy to result
// - done request with result latch
// - reset clears mode, channel, result
// - mode bit or byte writes, channel halfword or word writes at lane 0 only
// - standby halts conversion
// - one conversion per valid trigger edge
// - software mode repeats conversions back to back
// - channel write aborts and restarts
// - enable clear stops, enable set restarts
module sads_top
	import sads_pkg::*;
(
	// ahb-lite clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// device control and trigger
	input wire logic standby,
	input wire logic external_trigger_in,
	// analog side
	input wire logic comp_high,
	output logic sample_en,
	output logic [7:0] tap_code,
	output logic [1:0] mux_sel,
	// conversion done request
	output logic conversion_done_request
);
	sads_cfg_if cfg();
	logic [7:0] mode_ff, nxt_mode;
	logic [7:0] chan_ff, nxt_chan;
	logic flag_ff, nxt_flag;
	logic wr_pend_ff, nxt_wr_pend;
	logic [17:0] addr_ff, nxt_addr;
	logic [2:0] size_ff, nxt_size;
	logic [1:0] lane_ff, nxt_lane;
	logic [31:0] rdata_ff, nxt_rdata;
	logic restart_ff, nxt_restart;
	logic edge_hit;
	logic rd_flag;
	logic [7:0] wbyte;
	logic addr_ok;

	// address phase capture, data phase write
	always_comb begin
		nxt_wr_pend = 1'b0;
		nxt_addr = addr_ff;
		nxt_size = size_ff;
		nxt_lane = lane_ff;
		if (hsel && hready && htrans[1]) begin
			nxt_wr_pend = hwrite;
			nxt_addr = {haddr[17:2], 2'b00};
			nxt_size = hsize;
			nxt_lane = haddr[1:0];
		end
	end

	// byte selected by lane; a byte access is the single-bit style write
	always_comb begin
		wbyte = hwdata[8 * lane_ff +: 8];
		addr_ok = (size_ff == 3'h0) || (lane_ff == 2'b00);
	end

	// register writes; done flag set wins over read clear
	always_comb begin
		nxt_mode = mode_ff;
		nxt_chan = chan_ff;
		nxt_restart = 1'b0;
		if (wr_pend_ff && addr_ok && addr_ff == SADS_MODE_BADDR) begin
			nxt_mode = wbyte;
			nxt_restart = wbyte[SADS_EN_BIT] & mode_ff[SADS_EN_BIT];
		end
		if (wr_pend_ff && size_ff != 3'h0 && lane_ff == 2'b00 &&
			addr_ff == SADS_CHAN_BADDR) begin
			nxt_chan = {6'h00, wbyte[1:0]};
			nxt_restart = 1'b1;
		end
		nxt_flag = cfg.done | (flag_ff & ~rd_flag);
	end

	// read data is registered at the address phase
	always_comb begin
		rd_flag = 1'b0;
		nxt_rdata = 32'h0000_0000;
		if (hsel && hready && htrans[1] && !hwrite) begin
			case ({haddr[17:2], 2'b00})
				SADS_MODE_BADDR: nxt_rdata = {24'h00_0000, mode_ff};
				SADS_CHAN_BADDR: nxt_rdata = {24'h00_0000, chan_ff};
				SADS_RESULT_BADDR: nxt_rdata = {24'h00_0000, cfg.result};
				SADS_STATUS_BADDR: begin
					nxt_rdata[SADS_ST_DONE_BIT] = flag_ff;
					nxt_rdata[SADS_ST_BUSY_BIT] = cfg.busy;
					rd_flag = 1'b1;
				end
				default: nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_ff <= SADS_MODE_RST;
			chan_ff <= SADS_CHAN_RST;
			flag_ff <= 1'b0;
			wr_pend_ff <= 1'b0;
			addr_ff <= 18'h00000;
			size_ff <= 3'h0;
			lane_ff <= 2'b00;
			rdata_ff <= 32'h0000_0000;
			restart_ff <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;
			chan_ff <= nxt_chan;
			flag_ff <= nxt_flag;
			wr_pend_ff <= nxt_wr_pend;
			addr_ff <= nxt_addr;
			size_ff <= nxt_size;
			lane_ff <= nxt_lane;
			rdata_ff <= nxt_rdata;
			restart_ff <= nxt_restart;
		end
	end

	// configuration to the sequencer
	always_comb begin
		cfg.enable = mode_ff[SADS_EN_BIT];
		cfg.hw_start = mode_ff[SADS_TRG_BIT];
		cfg.conv_code = mode_ff[SADS_FR_LSB +: 3];
		cfg.edge_sel = mode_ff[SADS_EDGE_LSB +: 2];
		cfg.channel = chan_ff[1:0];
		cfg.restart = restart_ff;
		hrdata = rdata_ff;
		hreadyout = 1'b1;
		hresp = 1'b0;
	end

	sads_edge_det u_edge (
		.hclk(hclk),
		.hresetn(hresetn),
		.trig_in(external_trigger_in),
		.edge_sel(cfg.edge_sel),
		.edge_hit(edge_hit)
	);

	sads_seq u_seq (
		.hclk(hclk),
		.hresetn(hresetn),
		.cfg(cfg.seq),
		.standby(standby),
		.edge_hit(edge_hit),
		.comp_high(comp_high),
		.sample_en(sample_en),
		.tap_code(tap_code),
		.mux_sel(mux_sel),
		.done_req(conversion_done_request)
	);
endmodule
`default_nettype wire

// *** verif/sads_analog.sv ***
// model of the analog side: channel mux, sample and hold, comparator
`default_nettype none
module sads_analog (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// input levels, channel n in byte n
	input wire logic [31:0] vin,
	// converter controls
	input wire logic [1:0] mux_sel,
	input wire logic sample_en,
	input wire logic [7:0] tap_code,
	// comparator decision
	output logic comp_high
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] hold_ff;
	// track the chosen input while sampling, hold it after, compare each cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_ff <= 8'h00;
			comp_high <= 1'b0;
		end else begin
			if (sample_en)
				hold_ff <= vin[{mux_sel, 3'h0} +: 8];
			comp_high <= hold_ff >= tap_code;
		end
	end
endmodule
`default_nettype wire

// *** verif/sads_asserts.sv ***
// checker: timing and bus relations seen at the converter top ports
`default_nettype none
module sads_asserts
	import sads_pkg::*;
(
	// bus side
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	// converter side
	input wire logic standby,
	input wire logic sample_en,
	input wire logic [7:0] tap_code,
	input wire logic conversion_done_request
);
	logic [7:0] samp_ff;
	logic [7:0] nxt_samp;
	logic [7:0] low_ff;
	logic [7:0] nxt_low;
	logic [7:0] last_samp_ff;
	logic [7:0] nxt_last_samp;
	logic [7:0] first_tap_ff;
	logic [7:0] nxt_first_tap;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// sampling run length, cycles since sampling ended, last run length and its first tap
	always_comb begin
		nxt_samp = sample_en ? samp_ff + 8'h01 : 8'h00;
		nxt_low = sample_en ? 8'h00 : low_ff + {7'h00, low_ff != 8'hff};
		nxt_last_samp = last_samp_ff;
		nxt_first_tap = first_tap_ff;
		if (samp_ff != 8'h00 && !sample_en) begin
			nxt_last_samp = samp_ff;
			nxt_first_tap = tap_code;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			samp_ff <= 8'h00;
			low_ff <= 8'h00;
			last_samp_ff <= 8'h00;
			first_tap_ff <= 8'h00;
		end else begin
			samp_ff <= nxt_samp;
			low_ff <= nxt_low;
			last_samp_ff <= nxt_last_samp;
			first_tap_ff <= nxt_first_tap;
		end
	end
	// a read of the channel word
	sequence s_chan_rd;
		hsel && hready && htrans[1] && !hwrite && haddr == {14'h0000, SADS_CHAN_BADDR};
	endsequence
	// judged at done: aborted runs by disable or standby never reach a done
	a_samp_len: assert property (conversion_done_request |->
		last_samp_ff inside {8'h06, 8'h08, 8'h0a, 8'h0c, 8'h10, 8'h14})
		else $error("sampling length off table");
	a_tap_half: assert property (conversion_done_request |-> first_tap_ff == 8'h80)
		else $error("first trial not at half scale");
	a_no_done_samp: assert property (sample_en |-> !conversion_done_request)
		else $error("done during sampling");
	a_trial_span: assert property (conversion_done_request |-> low_ff >= 8'h20)
		else $error("trials too short");
	a_done_gap: assert property (conversion_done_request |=> !conversion_done_request [*8])
		else $error("done pulses too close");
	a_standby_halt: assert property (standby [*2] |-> !sample_en && !conversion_done_request)
		else $error("activity in standby");
	a_chan_zeros: assert property (s_chan_rd |=> hrdata[31:2] == 30'h0)
		else $error("channel fixed bits not zero");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
endmodule
bind sads_top sads_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hrdata, .hresp, .standby, .sample_en, .tap_code, .conversion_done_request);
`default_nettype wire

// *** verif/sar_adc_sequencer_test.sv ***
// self-checking bench for the converter sequencer top
`default_nettype none
module sar_adc_sequencer_test
	import sads_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] addr_mode = {14'h0000, SADS_MODE_BADDR};
	localparam logic [31:0] addr_chan = {14'h0000, SADS_CHAN_BADDR};
	localparam logic [31:0] addr_res = {14'h0000, SADS_RESULT_BADDR};
	localparam logic [31:0] addr_stat = {14'h0000, SADS_STATUS_BADDR};
	localparam logic [31:0] st_done = 32'h1 << SADS_ST_DONE_BIT;
	localparam logic [31:0] st_busy = 32'h1 << SADS_ST_BUSY_BIT;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, standby = 1'b0, trig = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, vin = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hready, hresp, comp_high, sample_en, done;
	logic [7:0] tap_code;
	logic [1:0] mux_sel;
	int errors = 0, num_checks = 0, cyc = 0, dcnt = 0;
	int codes[6] = '{0, 1, 2, 4, 5, 6}; // longest, advised code first
	always #2 hclk = ~hclk;
	sads_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hrdata, .hreadyout(hready), .hresp, .standby, .external_trigger_in(trig), .comp_high,
		.sample_en, .tap_code, .mux_sel, .conversion_done_request(done));
	sads_analog ana_u (.hclk, .hresetn, .vin, .mux_sel, .sample_en, .tap_code, .comp_high);
	// watchdog and done pulse count
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (done === 1'b1)
			dcnt <= dcnt + 1;
		if (cyc == 20000) begin
			errors++;
			stop_test;
		end
	end
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// single transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
		input logic [2:0] sz, output logic [31:0] rd);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= sz;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] v;
		bus(1'b0, a, 32'h0, 3'h2, v);
		chk(nm, v, exp);
	endtask
	task automatic wdone;
		do @(posedge hclk); while (done !== 1'b1);
	endtask
	// expected sampling and total lengths per code
	function automatic int samp_of(input int c);
		return c == 0 ? 20 : c == 1 ? 16 : c == 2 ? 12 : c == 4 ? 10 : c == 5 ? 8 : 6;
	endfunction
	function automatic int len_of(input int c);
		return c == 0 ? 144 : c == 1 ? 120 : c == 2 ? 96 : c == 4 ? 72 : c == 5 ? 60 : 48;
	endfunction
	// main sequence
	initial begin
		logic [31:0] r;
		int ch, d, n, m, c0, lo, code;
		r = $urandom(81544);
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk("mode", addr_mode, 32'h0);
		rd_chk("chan", addr_chan, 32'h0);
		rd_chk("result", addr_res, 32'h0);
		rd_chk("unmapped", addr_res + 32'h8, 32'h0);
		// software start over every permitted code
		foreach (codes[i]) begin
			code = codes[i];
			lo = code < 3 ? 6 : 3;
			ch = $urandom_range(3);
			vin <= (i < 2) ? {4{i[0] ? 8'hff : 8'h00}} : $urandom;
			bus(1'b1, addr_chan, 32'(ch), 3'h2, r);
			bus(1'b1, addr_mode, {4{8'h80 | 8'(code << 3)}}, i[0] ? 3'h0 : 3'h2, r);
			for (d = 0; sample_en !== 1'b1; d++)
				@(posedge hclk);
			// half cycle plus lo..hi whole cycles, seen one edge later
			chk("start delay", d >= lo + 2 && d <= lo + (code < 3 ? 3 : 2), 1'b1);
			for (n = 0; sample_en === 1'b1; n++)
				@(posedge hclk);
			chk("sample len", n, samp_of(code));
			chk("channel", mux_sel, ch);
			for (m = n; done !== 1'b1; m++)
				@(posedge hclk);
			chk("conv len", m, len_of(code));
			rd_chk("result", addr_res, {24'h0, vin[8 * ch +: 8]});
			for (m = 0; done !== 1'b1; m++)
				@(posedge hclk);
			chk("back to back", m <= len_of(code) + 12, 1'b1);
			bus(1'b1, addr_mode, 32'h0, 3'h2, r); // stop before next code
			c0 = dcnt;
			repeat (200) @(posedge hclk);
			chk("stopped", dcnt - c0, 0);
		end
		// hardware start for each edge selection
		for (int e = 0; e < 4; e++) begin
			bus(1'b1, addr_mode, 32'h000000f0 | 32'(e << 1), 3'h2, r);
			c0 = dcnt;
			repeat (20) @(posedge hclk);
			trig <= 1'b1;
			repeat (120) @(posedge hclk);
			trig <= 1'b0;
			repeat (120) @(posedge hclk);
			chk("edge starts", dcnt - c0, e - e / 2);
		end
		bus(1'b1, addr_mode, 32'h0, 3'h2, r);
		// channel rewrite during trials aborts and restarts
		vin <= 32'hc8643219;
		bus(1'b1, addr_chan, 32'h0, 3'h2, r);
		bus(1'b1, addr_mode, 32'h000000b0, 3'h2, r);
		wdone; // first result is discarded
		while (sample_en !== 1'b1)
			@(posedge hclk);
		while (sample_en === 1'b1)
			@(posedge hclk);
		repeat (5) @(posedge hclk);
		bus(1'b1, addr_chan, 32'h3, 3'h2, r);
		wdone;
		rd_chk("done flag", addr_stat, st_done | st_busy);
		rd_chk("flag clear", addr_stat, st_busy);
		rd_chk("abort result", addr_res, 32'hc8);
		// standby halts the running sequence
		wdone;
		standby <= 1'b1;
		@(posedge hclk);
		c0 = dcnt;
		repeat (200) @(posedge hclk);
		chk("standby", dcnt - c0, 0);
		standby <= 1'b0;
		stop_test;
	end
endmodule
`default_nettype wire
